// >>> logic/ftc_delay.sv
`timescale 1ns/1ps
module ftc_delay (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic tick_i,
    input wire logic cond_i,
    input wire logic [ftc_pkg::TMR_W-1:0] limit_i,
    output logic hit_o
);

    logic [ftc_pkg::TMR_W-1:0] cnt_q;

    // Counts ticks while the condition holds; restarts when it drops.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_q <= '0;
            hit_o <= 1'b0;
        end
        else if (!cond_i)
        begin
            cnt_q <= '0;
            hit_o <= 1'b0;
        end
        else if (tick_i && !hit_o)
        begin
            cnt_q <= cnt_q + 1'b1;
            hit_o <= (cnt_q + 1'b1) >= limit_i;
        end
    end

endmodule : ftc_delay

// >>> logic/ftc_mode_ctrl.sv
`timescale 1ns/1ps
module ftc_mode_ctrl #(
    parameter int TICK_CYC_P = ftc_pkg::TICK_CYC,
    parameter int DOM_TICKS_P = ftc_pkg::DOM_TICKS,
    parameter int SLEEP_TICKS_P = ftc_pkg::SLEEP_TICKS,
    parameter int WAKE_TICKS_P = ftc_pkg::WAKE_TICKS,
    parameter int BUS_WAKE_TICKS_P = ftc_pkg::BUS_WAKE_TICKS,
    parameter int FAIL_SET_TICKS_P = ftc_pkg::FAIL_SET_TICKS,
    parameter int FAIL_CLR_TICKS_P = ftc_pkg::FAIL_CLR_TICKS
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic txd_i,
    input wire logic standby_ctrl_n_i,
    input wire logic mode_sel_i,
    input wire logic wake_i,
    input wire logic canh_dom_i,
    input wire logic canl_dom_i,
    input wire logic diff_dom_i,
    input wire logic fail_high_wire_i,
    input wire logic fail_low_wire_i,
    input wire logic fail_diff_i,
    input wire logic vcc_ok_i,
    input wire logic vcc_por_ok_i,
    input wire logic vbat_ok_i,
    output logic rxd_o,
    output logic err_n_o,
    output logic regulator_on_out_o,
    output logic regulator_on_oe_n_o,
    output logic drive_dom_o,
    output logic high_drv_en_o,
    output logic low_drv_en_o,
    output logic high_wire_term_pin_en_o,
    output logic low_wire_term_pin_en_o,
    output logic low_wire_term_pin_bat_o,
    output logic single_wire_o,
    output logic [4:0] mode_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation and slow timebase.
    ftc_pkg::ftc_pins_s pins_raw;
    ftc_pkg::ftc_pins_s pins;
    logic [15:0] div_q;
    logic tick_q;
    assign pins_raw = '{txd: txd_i, standby_ctrl_n: standby_ctrl_n_i, mode_sel: mode_sel_i,
                        wake: wake_i, canh_dom: canh_dom_i, canl_dom: canl_dom_i,
                        diff_dom: diff_dom_i,
                        fail: {fail_diff_i, fail_low_wire_i, fail_high_wire_i},
                        vcc_ok: vcc_ok_i, vcc_por_ok: vcc_por_ok_i, vbat_ok: vbat_ok_i};
    ftc_sync #(
        .W($bits(ftc_pkg::ftc_pins_s))
    ) u_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .d_i(pins_raw),
        .q_o(pins)
    );
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            div_q <= '0;
            tick_q <= 1'b0;
        end
        else if (div_q == 16'(TICK_CYC_P - 1))
        begin
            div_q <= '0;
            tick_q <= 1'b1;
        end
        else
        begin
            div_q <= div_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode state and supply fail-safe.
    ftc_pkg::ftc_mode_e state_q;
    ftc_pkg::ftc_mode_e state_d;
    logic is_normal;
    logic low_power;
    logic stb_eff;
    logic en_eff;
    logic wake_q;
    logic power_flag_q;
    logic sleep_hold_hit;
    assign is_normal = (state_q == ftc_pkg::FTC_NORMAL);
    assign low_power = !is_normal;
    // Missing logic supply or battery reads both control pins as low.
    assign stb_eff = pins.standby_ctrl_n && pins.vcc_ok && pins.vbat_ok;
    assign en_eff = pins.mode_sel && pins.vcc_ok && pins.vbat_ok;
    ftc_delay u_sleep_hold (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .tick_i(tick_q),
        .cond_i(state_q == ftc_pkg::FTC_GOSLEEP),
        .limit_i(ftc_pkg::TMR_W'(SLEEP_TICKS_P)),
        .hit_o(sleep_hold_hit)
    );
    always_comb
    begin
        state_d = state_q;
        if (pins.vcc_por_ok)
        begin
            unique case (state_q)
                ftc_pkg::FTC_NORMAL,
                ftc_pkg::FTC_STANDBY,
                ftc_pkg::FTC_PWRSTBY:
                begin
                    unique case ({stb_eff, en_eff})
                        2'b11: state_d = ftc_pkg::FTC_NORMAL;
                        2'b10: state_d = ftc_pkg::FTC_PWRSTBY;
                        2'b01: state_d = (state_q == ftc_pkg::FTC_NORMAL) ? ftc_pkg::FTC_GOSLEEP
                                                                         : state_q;
                        2'b00: state_d = ftc_pkg::FTC_STANDBY;
                    endcase
                end
                ftc_pkg::FTC_GOSLEEP:
                begin
                    if (stb_eff && en_eff)
                        state_d = ftc_pkg::FTC_NORMAL;
                    else if (stb_eff)
                        state_d = ftc_pkg::FTC_PWRSTBY;
                    else if (!en_eff || wake_q || !pins.vbat_ok)
                        state_d = ftc_pkg::FTC_STANDBY;
                    else if (sleep_hold_hit)
                        state_d = ftc_pkg::FTC_SLEEP;
                end
                ftc_pkg::FTC_SLEEP:
                begin
                    if (stb_eff && en_eff)
                        state_d = ftc_pkg::FTC_NORMAL;
                    else if (stb_eff)
                        state_d = ftc_pkg::FTC_PWRSTBY;
                    else if (wake_q || !pins.vbat_ok)
                        state_d = ftc_pkg::FTC_STANDBY;
                end
            endcase
        end
        else if (state_q == ftc_pkg::FTC_SLEEP && (wake_q || !pins.vbat_ok))
            state_d = ftc_pkg::FTC_STANDBY;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            state_q <= ftc_pkg::MODE_RST;
        else
            state_q <= state_d;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Wake-up detection and power-on flag.
    logic wake_lvl_q;
    logic local_hit;
    logic bus_hit;
    ftc_delay u_local_wake (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .tick_i(tick_q),
        .cond_i(low_power && (pins.wake != wake_lvl_q)),
        .limit_i(ftc_pkg::TMR_W'(WAKE_TICKS_P)),
        .hit_o(local_hit)
    );
    ftc_delay u_bus_wake (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .tick_i(tick_q),
        .cond_i(low_power && (pins.canh_dom || pins.canl_dom)),
        .limit_i(ftc_pkg::TMR_W'(BUS_WAKE_TICKS_P)),
        .hit_o(bus_hit)
    );
    // The accepted wake level follows the pin in normal mode, so only
    // a debounced change seen in a low-power mode counts as a request.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            wake_lvl_q <= 1'b0;
        else if (is_normal || local_hit)
            wake_lvl_q <= pins.wake;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            wake_q <= 1'b0;
        else if (low_power && (local_hit || bus_hit))
            wake_q <= 1'b1;
        else if (state_d == ftc_pkg::FTC_NORMAL)
            wake_q <= 1'b0;
    end
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            power_flag_q <= ftc_pkg::POWER_FLAG_RST;
        else if (!pins.vbat_ok)
            power_flag_q <= 1'b1;
        else if (state_d == ftc_pkg::FTC_NORMAL)
            power_flag_q <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Failure filters and dominant timeout.
    logic [ftc_pkg::FAIL_N-1:0] fail_set_hit;
    logic [ftc_pkg::FAIL_N-1:0] fail_clr_hit;
    logic [ftc_pkg::FAIL_N-1:0] fail_q;
    logic [ftc_pkg::FAIL_N-1:0] fail_run;
    logic dom_hit;
    // Only the wire-disabling classes keep running in low-power modes.
    assign fail_run = is_normal ? '1 : ftc_pkg::FAIL_N'(3'b011);
    for (genvar g = 0; g < ftc_pkg::FAIL_N; g++)
    begin : g_fail
        ftc_delay u_set (
            .clk_i(clk_i),
            .arst_n_i(arst_n_i),
            .tick_i(tick_q),
            .cond_i(fail_run[g] && pins.fail[g] && !fail_q[g]),
            .limit_i(ftc_pkg::TMR_W'(FAIL_SET_TICKS_P)),
            .hit_o(fail_set_hit[g])
        );
        ftc_delay u_clr (
            .clk_i(clk_i),
            .arst_n_i(arst_n_i),
            .tick_i(tick_q),
            .cond_i(fail_run[g] && !pins.fail[g] && fail_q[g]),
            .limit_i(ftc_pkg::TMR_W'(FAIL_CLR_TICKS_P)),
            .hit_o(fail_clr_hit[g])
        );
        always_ff @(posedge clk_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
                fail_q[g] <= 1'b0;
            else if (fail_set_hit[g])
                fail_q[g] <= 1'b1;
            else if (fail_clr_hit[g])
                fail_q[g] <= 1'b0;
        end
    end
    ftc_delay u_dom_timeout (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .tick_i(tick_q),
        .cond_i(is_normal && !pins.txd),
        .limit_i(ftc_pkg::TMR_W'(DOM_TICKS_P)),
        .hit_o(dom_hit)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs.
    ftc_pkg::ftc_drv_s drv_d;
    logic normal_d;
    logic rx_dom;
    assign normal_d = (state_d == ftc_pkg::FTC_NORMAL);
    // A differential-class failure never reconfigures the stages, so a
    // frame in progress is not disturbed by it or by its recovery.
    always_comb
    begin
        drv_d.drive_dom = normal_d && !pins.txd && !dom_hit;
        drv_d.high_drv_en = normal_d && !fail_q[ftc_pkg::FAIL_H];
        drv_d.low_drv_en = normal_d && !fail_q[ftc_pkg::FAIL_L];
        drv_d.high_term_en = !fail_q[ftc_pkg::FAIL_H];
        drv_d.low_term_en = normal_d && !fail_q[ftc_pkg::FAIL_L];
        drv_d.low_term_bat = !normal_d && !fail_q[ftc_pkg::FAIL_L];
    end

    // Receive path picks the healthy wire in single-wire operation.
    always_comb
    begin
        if (fail_q[ftc_pkg::FAIL_H])
            rx_dom = pins.canl_dom;
        else if (fail_q[ftc_pkg::FAIL_L])
            rx_dom = pins.canh_dom;
        else
            rx_dom = pins.diff_dom;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            drive_dom_o <= 1'b0;
            high_drv_en_o <= 1'b0;
            low_drv_en_o <= 1'b0;
            high_wire_term_pin_en_o <= 1'b1;
            low_wire_term_pin_en_o <= 1'b0;
            low_wire_term_pin_bat_o <= 1'b1;
            single_wire_o <= 1'b0;
        end
        else
        begin
            drive_dom_o <= drv_d.drive_dom;
            high_drv_en_o <= drv_d.high_drv_en;
            low_drv_en_o <= drv_d.low_drv_en;
            high_wire_term_pin_en_o <= drv_d.high_term_en;
            low_wire_term_pin_en_o <= drv_d.low_term_en;
            low_wire_term_pin_bat_o <= drv_d.low_term_bat;
            single_wire_o <= fail_q[ftc_pkg::FAIL_H] || fail_q[ftc_pkg::FAIL_L];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rxd_o <= 1'b1;
            err_n_o <= 1'b1;
        end
        else if (normal_d)
        begin
            rxd_o <= !rx_dom;
            err_n_o <= !(|fail_q);
        end
        else
        begin
            rxd_o <= !wake_q;
            err_n_o <= (state_d == ftc_pkg::FTC_PWRSTBY) ? !power_flag_q : !wake_q;
        end
    end

    // Regulator enable floats only in sleep; sleep is left on any wake.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            regulator_on_out_o <= 1'b1;
            regulator_on_oe_n_o <= 1'b0;
            mode_o <= ftc_pkg::MODE_RST;
        end
        else
        begin
            regulator_on_out_o <= (state_d != ftc_pkg::FTC_SLEEP);
            regulator_on_oe_n_o <= (state_d == ftc_pkg::FTC_SLEEP);
            mode_o <= state_d;
        end
    end

endmodule : ftc_mode_ctrl

// >>> logic/ftc_pkg.sv
package ftc_pkg;

    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_US = TICK_PERIOD_NS / 1000;

    // Timer limits are 16 bits wide; all counts stay far below that.
    localparam int TMR_W = 16;

    // Least time in ticks, plus one tick for the unknown phase of the divider.
    function automatic int ftc_min_ticks(input int us);
        ftc_min_ticks = (us + TICK_US - 1) / TICK_US + 1;
    endfunction : ftc_min_ticks

    // Dominant timeout of transmit data, 0.75 ms least, 4 ms most.
    localparam int DOM_TIMEOUT_US = 750;
    localparam int DOM_TICKS = ftc_min_ticks(DOM_TIMEOUT_US);
    // Go-to-sleep hold time, 5 us least, 50 us most.
    localparam int SLEEP_HOLD_US = 5;
    localparam int SLEEP_TICKS = ftc_min_ticks(SLEEP_HOLD_US);
    // Local wake debounce time, 7 us least, 38 us most.
    localparam int WAKE_DEB_US = 7;
    localparam int WAKE_TICKS = ftc_min_ticks(WAKE_DEB_US);
    // Bus wake time: five dominant bits at 125 kbit/s.
    localparam int BUS_WAKE_US = 40;
    localparam int BUS_WAKE_TICKS = ftc_min_ticks(BUS_WAKE_US);
    // Failure filter delays into and out of single-wire operation.
    localparam int FAIL_SET_US = 30;
    localparam int FAIL_SET_TICKS = ftc_min_ticks(FAIL_SET_US);
    localparam int FAIL_CLR_US = 60;
    localparam int FAIL_CLR_TICKS = ftc_min_ticks(FAIL_CLR_US);

    // Failure classes: high wire faulty, low wire faulty, differential-tolerant.
    localparam int FAIL_H = 0;
    localparam int FAIL_L = 1;
    localparam int FAIL_D = 2;
    localparam int FAIL_N = 3;

    localparam logic POWER_FLAG_RST = 1'b1;

    typedef enum logic [4:0] {
        FTC_NORMAL   = 5'b00001,
        FTC_GOSLEEP  = 5'b00010,
        FTC_SLEEP    = 5'b00100,
        FTC_STANDBY  = 5'b01000,
        FTC_PWRSTBY  = 5'b10000
    } ftc_mode_e;

    localparam ftc_mode_e MODE_RST = FTC_STANDBY;

    // Inputs from outside the clock domain, synchronised together.
    typedef struct packed {
        logic txd;
        logic standby_ctrl_n;
        logic mode_sel;
        logic wake;
        logic canh_dom;
        logic canl_dom;
        logic diff_dom;
        logic [FAIL_N-1:0] fail;
        logic vcc_ok;
        logic vcc_por_ok;
        logic vbat_ok;
    } ftc_pins_s;

    // Output stage and termination controls.
    typedef struct packed {
        logic drive_dom;
        logic high_drv_en;
        logic low_drv_en;
        logic high_term_en;
        logic low_term_en;
        logic low_term_bat;
    } ftc_drv_s;

endpackage : ftc_pkg

// >>> logic/ftc_sync.sv
`timescale 1ns/1ps
module ftc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit changes only once the second and third stages agree.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            q_o <= '0;
        else
            for (int i = 0; i < W; i++)
                if (s2_q[i] == s3_q[i])
                    q_o[i] <= s3_q[i];
    end

endmodule : ftc_sync

// >>> testbench/ftc_host_model.sv
`timescale 1ns/1ps
// Host side of the mode pins: applies requested pin codes one clock after the request.
module ftc_host_model (
    input wire logic clk_i,
    input wire logic [2:0] req_i,
    input wire logic rxd_i,
    input wire logic err_n_i,
    output logic standby_ctrl_n_o = 1'b0,
    output logic mode_sel_o = 1'b0,
    output logic txd_o = 1'b1,
    output logic wake_seen_o
);
    always @(posedge clk_i)
    begin
        standby_ctrl_n_o <= req_i[2];
        mode_sel_o <= req_i[1];
        txd_o <= req_i[0];
    end
    assign wake_seen_o = !rxd_i || !err_n_i;
endmodule : ftc_host_model

// >>> testbench/ftc_mode_ctrl_assertions.sv
`timescale 1ns/1ps
module ftc_mode_ctrl_checker #(
    parameter int TICK_CYC_P = ftc_pkg::TICK_CYC,
    parameter int DOM_TICKS_P = ftc_pkg::DOM_TICKS,
    parameter int SLEEP_TICKS_P = ftc_pkg::SLEEP_TICKS,
    parameter int FAIL_SET_TICKS_P = ftc_pkg::FAIL_SET_TICKS,
    parameter int FAIL_CLR_TICKS_P = ftc_pkg::FAIL_CLR_TICKS
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic txd_i,
    input wire logic vcc_ok_i,
    input wire logic vcc_por_ok_i,
    input wire logic vbat_ok_i,
    input wire logic fail_high_wire_i,
    input wire logic fail_low_wire_i,
    input wire logic fail_diff_i,
    input wire logic rxd_o,
    input wire logic err_n_o,
    input wire logic regulator_on_out_o,
    input wire logic regulator_on_oe_n_o,
    input wire logic drive_dom_o,
    input wire logic high_drv_en_o,
    input wire logic high_wire_term_pin_en_o,
    input wire logic single_wire_o,
    input wire logic [4:0] mode_o
);
    localparam int DOM_LIM = (DOM_TICKS_P + 2) * TICK_CYC_P + 8;
    localparam int SLP_LIM = (SLEEP_TICKS_P + 2) * TICK_CYC_P + 8;
    localparam int FSET_LIM = (FAIL_SET_TICKS_P + 2) * TICK_CYC_P + 8;
    localparam int FCLR_LIM = (FAIL_CLR_TICKS_P + 2) * TICK_CYC_P + 8;
    logic [15:0] dom_q;
    logic [15:0] ok_q;
    logic [15:0] fh_q;
    ////////////////////////////////////////////////////////////////////////
    // Cycle counts of conditions held in normal mode.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            dom_q <= '0;
            ok_q <= '0;
            fh_q <= '0;
        end
        else
        begin
            dom_q <= (mode_o[0] && !txd_i) ? dom_q + 16'h1 : '0;
            ok_q <= (mode_o[0] && !(fail_high_wire_i || fail_low_wire_i || fail_diff_i)) ? ok_q + 16'h1 : '0;
            fh_q <= (mode_o[0] && fail_high_wire_i) ? fh_q + 16'h1 : '0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    property p_onehot; $onehot(mode_o); endproperty
    a_onehot: assert property (p_onehot) else $error("mode not one-hot");
    property p_sleep_float; mode_o[2] [*2] |-> regulator_on_oe_n_o; endproperty
    a_sleep_float: assert property (p_sleep_float) else $error("regulator driven in sleep");
    property p_standby_on; mode_o[3] [*2] |-> regulator_on_out_o && !regulator_on_oe_n_o; endproperty
    a_standby_on: assert property (p_standby_on) else $error("regulator off in standby");
    property p_lp_quiet; (|mode_o[4:2]) [*2] |-> !drive_dom_o; endproperty
    a_lp_quiet: assert property (p_lp_quiet) else $error("bus driven in low power");
    property p_vbat_force; (!vbat_ok_i) [*8] |-> !mode_o[0] && regulator_on_out_o && !regulator_on_oe_n_o; endproperty
    a_vbat_force: assert property (p_vbat_force) else $error("low battery not forced");
    property p_vcc_force; (!vcc_ok_i && vcc_por_ok_i) [*8] |-> !mode_o[0] && !mode_o[1]; endproperty
    a_vcc_force: assert property (p_vcc_force) else $error("low logic supply not forced");
    property p_por_block; (!vcc_por_ok_i) [*8] |-> !$rose(mode_o[0]); endproperty
    a_por_block: assert property (p_por_block) else $error("mode change below reset level");
    property p_gosleep_bound; $rose(mode_o[1]) |-> ##[1:SLP_LIM] !mode_o[1]; endproperty
    a_gosleep_bound: assert property (p_gosleep_bound) else $error("go-sleep too long");
    property p_dom_release; dom_q >= DOM_LIM |-> !drive_dom_o; endproperty
    a_dom_release: assert property (p_dom_release) else $error("dominant not released");
    property p_err_clear; ok_q >= FCLR_LIM |-> err_n_o && !single_wire_o; endproperty
    a_err_clear: assert property (p_err_clear) else $error("fault flag stuck");
    property p_fail_high;
        fh_q >= FSET_LIM |-> !err_n_o && single_wire_o && !high_drv_en_o && !high_wire_term_pin_en_o;
    endproperty
    a_fail_high: assert property (p_fail_high) else $error("faulty wire not disabled");
    property p_wake_reg; $fell(rxd_o) && !mode_o[0] |-> ##[0:2] regulator_on_out_o && !regulator_on_oe_n_o; endproperty
    a_wake_reg: assert property (p_wake_reg) else $error("wake without regulator");
    c_sleep: cover property (mode_o[2]);
    c_wake: cover property ($fell(rxd_o) && mode_o[3]);
    c_dom: cover property (dom_q >= DOM_LIM);
endmodule : ftc_mode_ctrl_checker

bind ftc_mode_ctrl ftc_mode_ctrl_checker #(.TICK_CYC_P(TICK_CYC_P), .DOM_TICKS_P(DOM_TICKS_P),
    .SLEEP_TICKS_P(SLEEP_TICKS_P), .FAIL_SET_TICKS_P(FAIL_SET_TICKS_P), .FAIL_CLR_TICKS_P(FAIL_CLR_TICKS_P))
    i_ftc_mode_ctrl_checker (.clk_i, .arst_n_i, .txd_i, .vcc_ok_i, .vcc_por_ok_i, .vbat_ok_i, .fail_high_wire_i,
    .fail_low_wire_i, .fail_diff_i, .rxd_o, .err_n_o, .regulator_on_out_o, .regulator_on_oe_n_o, .drive_dom_o,
    .high_drv_en_o, .high_wire_term_pin_en_o, .single_wire_o, .mode_o);

// >>> testbench/ftc_mode_ctrl_tb.sv
`timescale 1ns/1ps
module ftc_mode_ctrl_tb;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [2:0] req = 3'b001;
    logic wake = 1'b0, canh = 1'b0, canl = 1'b0, diff = 1'b0, fh = 1'b0, fl = 1'b0, fd = 1'b0;
    logic vcc = 1'b1, vpor = 1'b1, vbat = 1'b1, floated = 1'b0;
    logic stb, en, txd, wake_seen, rxd, err_n, reg_on, reg_oe_n, drv, hen, len, hterm, lterm, lbat, single;
    logic [4:0] mode;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 32'hbe88e2dc;
    int i;
    int n;
    always #2.5 clk_i = ~clk_i;
    ftc_host_model i_ftc_host_model (.clk_i(clk_i), .req_i(req), .rxd_i(rxd), .err_n_i(err_n),
        .standby_ctrl_n_o(stb), .mode_sel_o(en), .txd_o(txd), .wake_seen_o(wake_seen));
    ftc_mode_ctrl #(.TICK_CYC_P(4), .WAKE_TICKS_P(3), .BUS_WAKE_TICKS_P(4),
        .FAIL_SET_TICKS_P(3), .FAIL_CLR_TICKS_P(5)) i_ftc_mode_ctrl (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .txd_i(txd), .standby_ctrl_n_i(stb), .mode_sel_i(en), .wake_i(wake), .canh_dom_i(canh), .canl_dom_i(canl),
        .diff_dom_i(diff), .fail_high_wire_i(fh), .fail_low_wire_i(fl), .fail_diff_i(fd), .vcc_ok_i(vcc),
        .vcc_por_ok_i(vpor), .vbat_ok_i(vbat), .rxd_o(rxd), .err_n_o(err_n), .regulator_on_out_o(reg_on),
        .regulator_on_oe_n_o(reg_oe_n), .drive_dom_o(drv), .high_drv_en_o(hen), .low_drv_en_o(len),
        .high_wire_term_pin_en_o(hterm), .low_wire_term_pin_en_o(lterm), .low_wire_term_pin_bat_o(lbat),
        .single_wire_o(single), .mode_o(mode));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [4:0] seen, input logic [4:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic setp(input logic [2:0] r);
        @(posedge clk_i);
        req <= r;
    endtask : setp
    task automatic wait_mode(input logic [4:0] exp);
        for (n = 0; n < 80 && mode !== exp; n++)
            cyc(1);
        check(mode, exp);
    endtask : wait_mode
    // Transmitter drives dominant only in normal mode while transmit data is low.
    function automatic logic exp_drive(input logic t, input logic [4:0] m);
        return (m == ftc_pkg::FTC_NORMAL) && !t;
    endfunction : exp_drive
    always @(posedge clk_i)
    begin
        if (reg_oe_n === 1'b1)
            floated <= 1'b1;
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(4);
        @(posedge clk_i) arst_n_i <= 1'b1;
        cyc(1);
        check(mode, ftc_pkg::FTC_STANDBY);
        check({reg_on, reg_oe_n}, 5'h2);
        setp(3'b101);
        wait_mode(ftc_pkg::FTC_PWRSTBY);
        cyc(2);
        check({err_n, rxd}, 5'h1);
        setp(3'b111);
        wait_mode(ftc_pkg::FTC_NORMAL);
        cyc(2);
        check(err_n, 1'b1);
        for (i = 0; i < 24; i++)
        begin
            @(posedge clk_i);
            req <= {2'b11, 1'($random(seed))};
            diff <= 1'($random(seed));
            canh <= 1'($random(seed));
            canl <= 1'($random(seed));
            cyc(8);
            check(drv, exp_drive(txd, ftc_pkg::FTC_NORMAL));
            check(rxd, !diff);
        end
        setp(3'b110);
        cyc(12);
        check(drv, 1'b1);
        // Four clocks make one microsecond here: still dominant short of 0.75 ms, released long before 4 ms.
        cyc(2700);
        check(drv, 1'b1);
        cyc(310);
        check(drv, 1'b0);
        setp(3'b111);
        for (i = 0; i < 3; i++)
        begin
            @(posedge clk_i) {fh, fl, fd} <= 3'b100 >> i;
            cyc(40);
            check(err_n, 1'b0);
            check(single, i < 2);
            check(rxd, !(i == 0 ? canl : (i == 1 ? canh : diff)));
            check({hen, len, hterm, lterm}, {i != 0, i != 1, i != 0, i != 1});
            @(posedge clk_i) {fh, fl, fd} <= 3'b000;
            cyc(50);
            check({err_n, single}, 5'h2);
        end
        @(posedge clk_i) fh <= 1'b1;
        @(posedge clk_i) fh <= 1'b0;
        cyc(30);
        check(err_n, 1'b1);
        @(posedge clk_i) {canh, canl} <= 2'b00;
        // Wake sources in turn: wake rise, low line, wake fall, high line.
        for (i = 0; i < 4; i++)
        begin
            setp(3'b011);
            wait_mode(ftc_pkg::FTC_SLEEP);
            check(n >= 6 + ftc_pkg::SLEEP_HOLD_US * 4, 1'b1);
            check({reg_oe_n, lbat}, 5'h3);
            @(posedge clk_i)
            begin
                wake <= (i < 2);
                canl <= (i == 1);
                canh <= (i == 3);
            end
            wait_mode(ftc_pkg::FTC_STANDBY);
            check({rxd, err_n, reg_on, reg_oe_n}, 5'h2);
            check(wake_seen, 1'b1);
            @(posedge clk_i) {canl, canh} <= 2'b00;
            setp(3'b111);
            wait_mode(ftc_pkg::FTC_NORMAL);
        end
        // Leave go-sleep by another low-power code, then by a local wake.
        for (i = 0; i < 2; i++)
        begin
            setp(3'b011);
            wait_mode(ftc_pkg::FTC_GOSLEEP);
            @(posedge clk_i)
            begin
                floated <= 1'b0;
                req <= i ? 3'b011 : 3'b001;
                wake <= wake ^ (i == 1);
            end
            wait_mode(ftc_pkg::FTC_STANDBY);
            check(floated, 1'b0);
            setp(3'b111);
            wait_mode(ftc_pkg::FTC_NORMAL);
        end
        @(posedge clk_i) vpor <= 1'b0;
        cyc(10);
        setp(3'b001);
        cyc(15);
        check(mode, ftc_pkg::FTC_NORMAL);
        @(posedge clk_i) vpor <= 1'b1;
        wait_mode(ftc_pkg::FTC_STANDBY);
        setp(3'b111);
        wait_mode(ftc_pkg::FTC_NORMAL);
        for (i = 0; i < 2; i++)
        begin
            @(posedge clk_i) {vcc, vbat} <= i ? 2'b10 : 2'b01;
            wait_mode(ftc_pkg::FTC_STANDBY);
            check({reg_on, reg_oe_n}, 5'h2);
            @(posedge clk_i) {vcc, vbat} <= 2'b11;
            wait_mode(ftc_pkg::FTC_NORMAL);
        end
        conclude();
    end
endmodule : ftc_mode_ctrl_tb
